/* design/cspd_clock_stop_powerdown_control.sv */
// Clock stop and power-down control for a multi-output clock generator
`timescale 1ns/10ps
module cspd_clock_stop_powerdown_control
    import cspd_pkg::*;
#(
    parameter int HOST_DIV       = 2,
    parameter int BUS_DIV        = 8,
    parameter int PD_EXIT_CNT    = PD_EXIT_CYCLES,
    parameter int POWERUP_CNT    = POWERUP_CYCLES
) (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rstn_i,
    input  wire logic                    host_family_select_i,
    input  wire logic                    host_clock_stop_n_i,
    input  wire logic                    bus_clock_stop_n_i,
    input  wire logic                    power_down_n_i,
    input  wire logic                    termination_power_good_n_i,
    input  wire logic [NUM_OUTS-1:0]     out_enable_i,
    output logic [HOST_PAIRS-1:0]        host_clk_true_o,
    output logic [HOST_PAIRS-1:0]        host_clk_comp_o,
    output logic [HOST_PAIRS-1:0]        host_clk_comp_oe_o,
    output logic [1:0]                   host_true_drive_o,
    output logic                         chipset_host_clk_comp_o,
    output logic [BUS_OUTS-1:0]          bus_clk_o,
    output logic                         bus_clk_free_o,
    output logic [NUM_OUTS-1:0]          out_enable_o,
    output logic                         mode_diff_o,
    output cspd_status_t                 status_o
);
    localparam int HDW = $clog2(HOST_DIV);
    localparam int BDW = $clog2(BUS_DIV);
    // Waits end early so sync, hand-over and first bus pulse still fit the ceiling
    localparam int START_SLACK  = BUS_DIV + 8;
    localparam int WAKE_LAST    = (PD_EXIT_CNT > START_SLACK)
                                  ? PD_EXIT_CNT - START_SLACK - 1 : 0;
    localparam int POWERUP_LAST = (POWERUP_CNT > START_SLACK)
                                  ? POWERUP_CNT - START_SLACK - 1 : 0;

    // Synchronised inputs
    logic host_stop_n_s;
    logic bus_stop_n_s;
    logic pd_n_s;
    logic pgood_n_s;

    // Stop, power-down and power-good inputs pass two flops on the system clock
    cspd_sync #(.RESET_VAL(1'b1)) u_sync_hstop (
        .clk_i  (clk_sys_i),
        .rstn_i (rstn_i),
        .d_i    (host_clock_stop_n_i),
        .q_o    (host_stop_n_s)
    );
    cspd_sync #(.RESET_VAL(1'b1)) u_sync_bstop (
        .clk_i  (clk_sys_i),
        .rstn_i (rstn_i),
        .d_i    (bus_clock_stop_n_i),
        .q_o    (bus_stop_n_s)
    );
    cspd_sync #(.RESET_VAL(1'b1)) u_sync_pd (
        .clk_i  (clk_sys_i),
        .rstn_i (rstn_i),
        .d_i    (power_down_n_i),
        .q_o    (pd_n_s)
    );
    cspd_sync #(.RESET_VAL(1'b1)) u_sync_pg (
        .clk_i  (clk_sys_i),
        .rstn_i (rstn_i),
        .d_i    (termination_power_good_n_i),
        .q_o    (pgood_n_s)
    );

    // Strap latch, caught after reset release
    logic mode_reg;
    logic mode_next;
    logic strap_done_reg;
    logic strap_done_next;
    logic pg_seen_reg;
    logic pg_seen_next;
    logic pg_prev_reg;
    logic pg_prev_next;

    // Mode strap taken once; power good acts only once
    always_comb begin
        mode_next       = mode_reg;
        strap_done_next = 1'b1;
        if (!strap_done_reg) begin
            mode_next = host_family_select_i;
        end
        pg_prev_next = pgood_n_s;
        pg_seen_next = pg_seen_reg;
        if (pg_prev_reg && !pgood_n_s) begin
            pg_seen_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_reg       <= HOST_FAMILY_DIFF;
            strap_done_reg <= 1'b0;
            pg_seen_reg    <= 1'b0;
            pg_prev_reg    <= 1'b1;
        end else begin
            mode_reg       <= mode_next;
            strap_done_reg <= strap_done_next;
            pg_seen_reg    <= pg_seen_next;
            pg_prev_reg    <= pg_prev_next;
        end
    end

    // Power good only matters in differential mode; open-drain ignores it
    logic pg_ok;
    assign pg_ok = pg_seen_reg || (mode_reg == HOST_FAMILY_OD);

    // Clock phase dividers stand in for the PLL outputs
    logic [HDW-1:0] hdiv_reg;
    logic [HDW-1:0] hdiv_next;
    logic [BDW-1:0] bdiv_reg;
    logic [BDW-1:0] bdiv_next;
    logic           pll_run;
    logic           host_phase;
    logic           bus_phase;
    logic           host_rise;

    // Dividers halt with the PLL in power-down
    always_comb begin
        hdiv_next = hdiv_reg;
        bdiv_next = bdiv_reg;
        if (pll_run) begin
            hdiv_next = hdiv_reg + 1'b1;
            bdiv_next = bdiv_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hdiv_reg <= '0;
            bdiv_reg <= '0;
        end else begin
            hdiv_reg <= hdiv_next;
            bdiv_reg <= bdiv_next;
        end
    end

    assign host_phase = ~hdiv_reg[HDW-1];
    assign bus_phase  = ~bdiv_reg[BDW-1];
    // Rising edge of the complementary host clock, as seen internally
    assign host_rise  = pll_run && (hdiv_reg == HDW'(HOST_DIV / 2 - 1));

    // Two-edge qualifiers for host stop and power-down
    logic [1:0] hstop_cnt_reg;
    logic [1:0] hstop_cnt_next;
    logic [1:0] pd_cnt_reg;
    logic [1:0] pd_cnt_next;

    // Low level must be seen on two rising complementary edges
    always_comb begin
        hstop_cnt_next = hstop_cnt_reg;
        pd_cnt_next    = pd_cnt_reg;
        if (host_stop_n_s) begin
            hstop_cnt_next = 2'h0;
        end else if (host_rise && hstop_cnt_reg != 2'h2) begin
            hstop_cnt_next = hstop_cnt_reg + 2'h1;
        end
        if (pd_n_s) begin
            pd_cnt_next = 2'h0;
        end else if (host_rise && pd_cnt_reg != 2'h2) begin
            pd_cnt_next = pd_cnt_reg + 2'h1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hstop_cnt_reg <= 2'h0;
            pd_cnt_reg    <= 2'h0;
        end else begin
            hstop_cnt_reg <= hstop_cnt_next;
            pd_cnt_reg    <= pd_cnt_next;
        end
    end

    // Main power state machine
    cspd_state_t      state_reg;
    cspd_state_t      state_next;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] timer_next;
    logic             gate_idle;

    // Power-up wait, run, power-down and wake latency
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        unique case (state_reg)
            CSPD_POWERUP: begin
                timer_next = timer_reg + 1'b1;
                if (timer_reg >= TIMER_W'(POWERUP_LAST) && pg_ok) begin
                    state_next = CSPD_RUN;
                    timer_next = '0;
                end
            end
            CSPD_RUN: begin
                // Wait for every gate to settle low before PLL shutdown
                if (pd_cnt_reg == 2'h2 && gate_idle) begin
                    state_next = CSPD_PD;
                end
            end
            CSPD_PD: begin
                if (pd_n_s) begin
                    state_next = CSPD_WAKE;
                    timer_next = '0;
                end
            end
            CSPD_WAKE: begin
                // Oscillator and PLL relock, kept under the latency ceiling
                timer_next = timer_reg + 1'b1;
                if (!pd_n_s) begin
                    state_next = CSPD_PD;
                end else if (timer_reg >= TIMER_W'(WAKE_LAST)) begin
                    state_next = CSPD_RUN;
                    timer_next = '0;
                end
            end
            default: begin
                state_next = CSPD_POWERUP;
                timer_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= CSPD_POWERUP;
            timer_reg <= '0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
        end
    end

    logic running;
    logic pd_pending;
    assign running    = (state_reg == CSPD_RUN);
    assign pd_pending = (pd_cnt_reg == 2'h2);
    // Oscillator and PLL are off only in power-down
    assign pll_run    = (state_reg != CSPD_PD);

    // Run requests per output; power-down overrides all
    logic [NUM_OUTS-1:0] run_req;
    logic [NUM_OUTS-1:0] gate_out;
    logic                host_stop;
    assign host_stop = (hstop_cnt_reg == 2'h2);

    // Output map: 0..1 host pairs, 2 chipset, 3..8 bus, 9..15 spare; free bus clock has its own flop
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUTS; gi++) begin : g_out
            logic is_host;
            logic is_bus;
            logic phase;
            logic rest_hi;
            assign is_host = (gi < HOST_PAIRS);
            assign is_bus  = (gi >= 3) && (gi < 3 + BUS_OUTS);
            assign phase   = (gi < 3) ? host_phase : bus_phase;
            // Host pairs rest high on host stop, but low in power-down
            assign rest_hi = is_host && host_stop && !pd_pending;
            assign run_req[gi] = running && !pd_pending && out_enable_i[gi]
                                 && !(is_host && host_stop)
                                 && !(is_bus && !bus_stop_n_s);
            // Gating only at phase boundaries keeps full high phases
            cspd_gate u_gate (
                .clk_i       (clk_sys_i),
                .rstn_i      (rstn_i),
                .phase_i     (phase),
                .run_i       (run_req[gi]),
                .rest_high_i (rest_hi),
                .clk_o       (gate_out[gi])
            );
        end
    endgenerate

    // All outputs low before the PLLs stop
    assign gate_idle = (gate_out == '0);

    // Free-running bus clock ignores bus stop; still stops in power-down
    logic free_reg;
    logic free_next;
    always_comb begin
        free_next = 1'b0;
        if (pll_run && state_reg != CSPD_POWERUP && !pd_pending) begin
            free_next = bus_phase;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            free_reg <= 1'b0;
        end else begin
            free_reg <= free_next;
        end
    end

    // Host drive and complement enable registered
    logic [1:0]            drive_reg;
    logic [1:0]            drive_next;
    logic [HOST_PAIRS-1:0] comp_oe_reg;
    logic [HOST_PAIRS-1:0] comp_oe_next;
    logic [HOST_PAIRS-1:0] comp_reg;
    logic [HOST_PAIRS-1:0] comp_next;

    always_comb begin
        drive_next = DRIVE_MULT;
        if (mode_reg == HOST_FAMILY_DIFF && state_reg == CSPD_PD) begin
            drive_next = DRIVE_DOUBLE;
        end
        for (int i = 0; i < HOST_PAIRS; i++) begin
            // Complement floats only once the true output sits at its high rest;
            // a high phase of a still running pair must not release it
            comp_oe_next[i] = !(host_stop && !pd_pending && gate_out[i]
                                && (host_phase || !comp_oe_reg[i]));
            comp_next[i]    = comp_oe_next[i] && run_req[i] ? ~host_phase : 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            drive_reg   <= DRIVE_MULT;
            comp_oe_reg <= '1;
            comp_reg    <= '0;
        end else begin
            drive_reg   <= drive_next;
            comp_oe_reg <= comp_oe_next;
            comp_reg    <= comp_next;
        end
    end

    // Output assignments
    assign host_clk_true_o         = gate_out[HOST_PAIRS-1:0];
    assign host_clk_comp_o         = comp_reg;
    assign host_clk_comp_oe_o      = comp_oe_reg;
    assign host_true_drive_o       = drive_reg;
    assign chipset_host_clk_comp_o = gate_out[2];
    assign bus_clk_o               = gate_out[3 +: BUS_OUTS];
    assign bus_clk_free_o          = free_reg;
    assign out_enable_o            = out_enable_i;
    assign mode_diff_o             = mode_reg;
    // Serial interface off while shut down
    assign status_o.pll_on         = pll_run;
    assign status_o.osc_on         = pll_run;
    assign status_o.serial_en      = (state_reg != CSPD_PD);
    assign status_o.stable         = running;
endmodule // cspd_clock_stop_powerdown_control

/* design/cspd_gate.sv */
// Glitch-free gate for one divided clock output, stops low or high
`timescale 1ns/10ps
module cspd_gate
    import cspd_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic phase_i,
    input  wire logic run_i,
    input  wire logic rest_high_i,
    output logic      clk_o
);
    logic out_reg;
    logic out_next;
    logic run_reg;
    logic run_next;

    // Run state changes only at the phase boundary matching the rest level,
    // so no pulse is ever shortened or stretched
    always_comb begin
        run_next = run_reg;
        if (phase_i == rest_high_i) begin
            run_next = run_i;
        end
        out_next = run_next ? phase_i : rest_high_i;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_reg <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
            out_reg <= out_next;
        end
    end

    assign clk_o = out_reg;
endmodule // cspd_gate

/* design/cspd_sync.sv */
// Two-flop synchroniser for an asynchronous level
`timescale 1ns/10ps
module cspd_sync
    import cspd_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_reg;
    logic q_reg;
    logic meta_next;
    logic q_next;

    // Only the second flop is seen outside
    always_comb begin
        meta_next = d_i;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= RESET_VAL;
            q_reg    <= RESET_VAL;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule // cspd_sync

/* shared/cspd_pkg.sv */
// Package with constants and types for the clock stop and power-down control
package cspd_pkg;

    // Host family encodings
    localparam logic HOST_FAMILY_DIFF = 1'b1;
    localparam logic HOST_FAMILY_OD   = 1'b0;

    // Synchroniser depth
    localparam int SYNC_STAGES = 2;

    // Output counts
    localparam int HOST_PAIRS  = 2;
    localparam int BUS_OUTS    = 6;
    localparam int NUM_OUTS    = 16;

    // Drive codes for host true output: multiplier or doubled reference
    localparam logic [1:0] DRIVE_MULT   = 2'h0;
    localparam logic [1:0] DRIVE_DOUBLE = 2'h1;

    // Timing: clock period and latencies
    localparam int  CLK_PERIOD_PS      = 4000;
    localparam int  PD_EXIT_TIME_US    = 1500;
    localparam int  POWERUP_TIME_US    = 1500;
    localparam int  PD_EXIT_CYCLES     = (PD_EXIT_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int  POWERUP_CYCLES     = (POWERUP_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int  TIMER_W            = 20;

    // Reset values
    localparam logic [NUM_OUTS-1:0] OUT_EN_RESET = 16'hFFFF;

    // Top-level state
    typedef enum logic [3:0] {
        CSPD_POWERUP = 4'h1,
        CSPD_RUN     = 4'h2,
        CSPD_PD      = 4'h4,
        CSPD_WAKE    = 4'h8
    } cspd_state_t;

    // Status bundle
    typedef struct packed {
        logic pll_on;
        logic osc_on;
        logic serial_en;
        logic stable;
    } cspd_status_t;

endpackage : cspd_pkg

/* tb/cspd_checker.sv */
// Concurrent checks on the ports of the clock stop and power-down control
`timescale 1ns/10ps
module cspd_checker
    import cspd_pkg::*;
#(
    parameter int HOST_DIV = 2,
    parameter int BUS_DIV  = 8
) (
    input wire logic                  clk_sys_i,
    input wire logic                  rstn_i,
    input wire logic                  host_family_select_i,
    input wire logic                  host_clock_stop_n_i,
    input wire logic                  bus_clock_stop_n_i,
    input wire logic [HOST_PAIRS-1:0] host_clk_true_o,
    input wire logic [HOST_PAIRS-1:0] host_clk_comp_o,
    input wire logic [HOST_PAIRS-1:0] host_clk_comp_oe_o,
    input wire logic [1:0]            host_true_drive_o,
    input wire logic                  chipset_host_clk_comp_o,
    input wire logic [BUS_OUTS-1:0]   bus_clk_o,
    input wire logic                  bus_clk_free_o,
    input wire logic                  mode_diff_o,
    input wire cspd_status_t          status_o
);
    localparam int BUS_WIN = BUS_DIV + 8;
    logic [1:0] rst_cnt_reg;
    logic [4:0] bstop_reg;

    // Saturating counts: cycles since reset, cycles of bus stop held low
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_cnt_reg <= 2'h0;
            bstop_reg   <= 5'h00;
        end else begin
            rst_cnt_reg <= (rst_cnt_reg == 2'h3) ? 2'h3 : rst_cnt_reg + 2'h1;
            bstop_reg   <= bus_clock_stop_n_i ? 5'h00 :
                           ((bstop_reg == 5'h1F) ? 5'h1F : bstop_reg + 5'h01);
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // Stop waits for the synchroniser and two host edges, then takes hold
    sequence s_host_rest;
        host_clk_comp_oe_o[0] [*3] ##[1:16] !host_clk_comp_oe_o[0];
    endsequence

    a_mode_latch: assert property (rst_cnt_reg == 2'h3 |-> mode_diff_o == host_family_select_i)
        else $error("latched mode differs from select");
    a_host_stop: assert property ($fell(host_clock_stop_n_i) && host_clk_comp_oe_o[0]
        && status_o.pll_on |-> s_host_rest) else $error("host stop timing wrong");
    a_host_rest: assert property (!host_clk_comp_oe_o[0] && status_o.pll_on |->
        host_clk_true_o[0] && !host_clk_comp_o[0]) else $error("host pair rest level wrong");
    a_host_resume: assert property ($rose(host_clock_stop_n_i) && !host_clk_comp_oe_o[0]
        |-> ##[1:12] host_clk_comp_oe_o[0]) else $error("host pair late to resume");
    a_bus_stopped: assert property (bstop_reg > 5'(BUS_DIV + 6) |-> bus_clk_o == '0)
        else $error("bus clock runs while stopped");
    a_free_toggle: assert property (!bus_clock_stop_n_i && status_o.pll_on
        |-> ##[1:BUS_DIV] $changed(bus_clk_free_o)) else $error("free bus clock halted");
    a_bus_resume: assert property ($rose(bus_clock_stop_n_i) && status_o.pll_on
        |-> ##[1:BUS_WIN] $rose(bus_clk_o[0])) else $error("bus clock late to resume");
    a_bus_high: assert property ($rose(bus_clk_o[0]) |-> bus_clk_o[0] [*4] ##1 !bus_clk_o[0])
        else $error("bus clock high phase cut");
    a_pd_low: assert property (!status_o.osc_on && !$past(status_o.osc_on) |->
        !status_o.pll_on && host_clk_true_o == '0 && bus_clk_o == '0 && !bus_clk_free_o
        && !chipset_host_clk_comp_o) else $error("output runs in power-down");
    a_drive_pd: assert property (mode_diff_o && !status_o.pll_on && !$past(status_o.pll_on)
        |-> host_true_drive_o == DRIVE_DOUBLE) else $error("power-down drive wrong");
endmodule // cspd_checker

bind cspd_clock_stop_powerdown_control cspd_checker #(.HOST_DIV(HOST_DIV), .BUS_DIV(BUS_DIV))
    u_chk (.clk_sys_i, .rstn_i, .host_family_select_i, .host_clock_stop_n_i,
    .bus_clock_stop_n_i, .host_clk_true_o, .host_clk_comp_o, .host_clk_comp_oe_o,
    .host_true_drive_o, .chipset_host_clk_comp_o, .bus_clk_o, .bus_clk_free_o,
    .mode_diff_o, .status_o);

/* tb/cspd_pm_model.sv */
// Power-management partner driving the stop, power-down and power-good pins
`timescale 1ns/10ps
module cspd_pm_model (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       slow_i,
    input  wire logic [3:0] req_i,
    output logic [3:0]      pins_n_o,
    output logic            cpu_power_o
);
    logic [3:0] req_reg;
    logic [3:0] pd_age_reg;

    // Pins change after the edge; slow mode answers one cycle later
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_reg     <= 4'h0;
            pins_n_o    <= 4'hF;
            pd_age_reg  <= 4'h0;
            cpu_power_o <= 1'b1;
        end else begin
            req_reg     <= req_i;
            pins_n_o    <= ~(slow_i ? req_reg : req_i);
            pd_age_reg  <= pins_n_o[2] ? 4'h0 : ((pd_age_reg == 4'hF) ? 4'hF : pd_age_reg + 4'h1);
            cpu_power_o <= pins_n_o[2] || (pd_age_reg < 4'h8);
        end
    end
endmodule // cspd_pm_model

/* tb/tb.sv */
// Self-checking bench for the clock stop and power-down control
`timescale 1ns/10ps
module tb;
    import cspd_pkg::*;
    localparam int CNT = 20;
    logic                  clk  = 1'b0;
    logic                  rstn = 1'b0;
    logic                  sel  = 1'b1;
    logic                  slow = 1'b0;
    logic [3:0]            req  = 4'h0;
    logic [NUM_OUTS-1:0]   oen  = OUT_EN_RESET;
    logic [3:0]            pins_n;
    logic                  cpu_pwr;
    logic [HOST_PAIRS-1:0] ht, hc, hoe;
    logic [1:0]            drv;
    logic                  chs, bfree, mode;
    logic [BUS_OUTS-1:0]   bclk, acc;
    logic [NUM_OUTS-1:0]   oen_o;
    logic [3:0]            seen;
    cspd_status_t          st;
    int                    errors = 0;
    int                    n_compared = 0;

    // System clock, 4 ns period
    initial begin
        forever #2 clk = ~clk;
    end

    cspd_pm_model pm (.clk_i(clk), .rstn_i(rstn), .slow_i(slow), .req_i(req),
        .pins_n_o(pins_n), .cpu_power_o(cpu_pwr));

    cspd_clock_stop_powerdown_control #(.PD_EXIT_CNT(CNT), .POWERUP_CNT(CNT)) dut (
        .clk_sys_i(clk), .rstn_i(rstn), .host_family_select_i(sel),
        .host_clock_stop_n_i(pins_n[0]), .bus_clock_stop_n_i(pins_n[1]),
        .power_down_n_i(pins_n[2]), .termination_power_good_n_i(pins_n[3]),
        .out_enable_i(oen), .host_clk_true_o(ht), .host_clk_comp_o(hc),
        .host_clk_comp_oe_o(hoe), .host_true_drive_o(drv), .chipset_host_clk_comp_o(chs),
        .bus_clk_o(bclk), .bus_clk_free_o(bfree), .out_enable_o(oen_o),
        .mode_diff_o(mode), .status_o(st));

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Lets n edges pass and samples at the falling edge, where outputs settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic drive(input int bit_no, input logic v);
        @(posedge clk);
        req[bit_no] <= v;
    endtask

    task automatic t_powerup(input logic m);
        @(posedge clk);
        rstn <= 1'b0;
        sel  <= m;
        req  <= 4'h0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        cyc(CNT + 30);
        check(16'(mode), 16'(m), "mode");
        check(16'(st.stable), 16'(!m), "stable early");
        drive(3, 1'b1);
        for (int i = 0; i < 40 && st.stable !== 1'b1; i++) cyc(1);
        check(16'(st.stable), 16'h0001, "stable");
        drive(3, 1'b0);
        cyc(20);
        check(16'(st.stable), 16'h0001, "second edge");
    endtask

    task automatic t_enable();
        @(posedge clk);
        oen <= 16'hFFF7;
        cyc(12);
        acc = '0;
        repeat (16) begin
            cyc(1);
            acc |= bclk;
        end
        check(oen_o, 16'hFFF7, "enable pass");
        check(16'(acc), 16'h003E, "own enable");
        @(posedge clk);
        oen <= OUT_EN_RESET;
    endtask

    task automatic t_host_stop();
        drive(0, 1'b1);
        cyc(24);
        check(16'({ht, hc, hoe}), 16'h0030, "host rest");
        check(16'(drv), 16'(DRIVE_MULT), "stop drive");
        drive(0, 1'b0);
        cyc(12);
        check(16'(hoe), 16'h0003, "host resume");
    endtask

    task automatic t_bus_stop();
        drive(1, 1'b1);
        cyc(20);
        acc = '0;
        seen = 4'h0;
        repeat (16) begin
            cyc(1);
            acc |= bclk;
            seen[{1'b0, bfree}] = 1'b1;
            seen[{1'b1, chs}] = 1'b1;
        end
        check(16'(acc), 16'h0000, "bus stopped");
        check(16'(seen), 16'h000F, "others run");
        drive(1, 1'b0);
        for (int i = 0; i < 16 && bclk[0] !== 1'b1; i++) cyc(1);
        check(16'(bclk[0]), 16'h0001, "bus resume");
    endtask

    task automatic t_pd(input logic m);
        drive(2, 1'b1);
        cyc(40);
        check(16'({st.pll_on, st.osc_on, st.serial_en}), 16'h0000, "pd status");
        check(16'({ht, chs, bclk, bfree}), 16'h0000, "pd low");
        if (m) check(16'(drv), 16'(DRIVE_DOUBLE), "pd drive");
        else check(16'(drv), 16'(DRIVE_MULT), "pd drive od");
        check(16'(cpu_pwr), 16'h0000, "cpu power off");
        drive(2, 1'b0);
        for (int i = 0; i < CNT && bclk[0] !== 1'b1; i++) cyc(1);
        check(16'({st.pll_on, bclk[0]}), 16'h0003, "wake");
    endtask

    task automatic final_report();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence: differential mode, then open-drain with a slow partner
    initial begin
        t_powerup(1'b1);
        t_enable();
        t_host_stop();
        t_bus_stop();
        t_pd(1'b1);
        slow <= 1'b1;
        t_powerup(1'b0);
        t_host_stop();
        t_bus_stop();
        t_pd(1'b0);
        final_report();
    end

    // Watchdog well beyond the roughly 600 cycles the tests need
    initial begin
        #80000;
        errors++;
        final_report();
    end
endmodule // tb
